// File: verilog/dtp_defines.svh
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

// Table entry layout: {offset, low limit, high limit, reset value}
`define DTP_TAB_OFS_HI    63
`define DTP_TAB_OFS_LO    48
`define DTP_TAB_MIN_HI    47
`define DTP_TAB_MIN_LO    32
`define DTP_TAB_MAX_HI    31
`define DTP_TAB_MAX_LO    16
`define DTP_TAB_RST_HI    15
`define DTP_TAB_RST_LO    0

`define DTP_R_RESTART_METHOD   {16'h10A5, 16'h0000, 16'h0003, 16'h0000}
`define DTP_R_UV_RIDE_TIME     {16'h10A6, 16'h0003, 16'h00FA, 16'h000A}
`define DTP_R_RESTART_WAIT     {16'h10A7, 16'h0003, 16'h03E8, 16'h000A}
`define DTP_R_PF_ALARM_EN      {16'h10A8, 16'h0000, 16'h0001, 16'h0000}
`define DTP_R_RESTART_COUNT    {16'h10A9, 16'h0000, 16'h0001, 16'h0000}
`define DTP_R_THERMAL_LEVEL    {16'h10AD, 16'h07D0, 16'h2EE0, 16'h2710}
`define DTP_R_THERMAL_CURVE    {16'h10AE, 16'h0000, 16'h0002, 16'h0001}
`define DTP_R_OL_MODE          {16'h10B5, 16'h0000, 16'h0002, 16'h0001}
`define DTP_R_OL_LEVEL         {16'h10B6, 16'h07D0, 16'h3A98, 16'h3A98}
`define DTP_R_OL_DECEL         {16'h10B7, 16'h0001, 16'h012C, 16'h000A}
`define DTP_R_OL_SOURCE        {16'h10BB, 16'h0000, 16'h0001, 16'h0000}
`define DTP_R_LOCK_MODE        {16'h10BC, 16'h0000, 16'h0003, 16'h0000}
`define DTP_R_AM_GAIN          {16'h10CF, 16'h0000, 16'h00FF, 16'h0064}
`define DTP_R_START_FREQ       {16'h10D1, 16'h0005, 16'h0063, 16'h0005}
`define DTP_R_THERMAL_LEVEL_M2 {16'h1526, 16'h07D0, 16'h2EE0, 16'h2710}
`define DTP_R_THERMAL_CURVE_M2 {16'h1527, 16'h0000, 16'h0002, 16'h0001}
`define DTP_R_OL_SOURCE_M2     {16'h152B, 16'h0000, 16'h0001, 16'h0000}

// Read-only status word
`define DTP_STATUS_OFS    16'h1600

// Lock mode codes at or above this ignore the lock terminal
`define DTP_LOCK_ALWAYS   16'h0002
// Codes with this bit set also free the frequency setpoint
`define DTP_LOCK_FREQ_BIT 0

// Restart method: alarm only
`define DTP_METHOD_ALARM  16'h0000
// Limited restart count
`define DTP_RESTART_LIMIT 5'd16

// Time base: 0.1 s steps on a 4 ns clock
`define DTP_STEP_NS       100000000
`define DTP_CLK_NS        4

`endif

// File: verilog/dtp_pkg.sv
package dtp_pkg;

	localparam int DTP_NREG = 17;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_RIDE = 2'b01,
		ST_WAIT = 2'b10,
		ST_TRIP = 2'b11
	} dtp_state_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} dtp_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} dtp_rsp_t;

	typedef struct packed {
		logic        motor_enable;
		logic        trip;
		logic        trip_alarm;
		logic        restart_pulse;
		logic        freq_match;
		logic        stop_after_match;
		logic [4:0]  restarts;
	} dtp_power_t;

endpackage

// File: verilog/dtp_range_chk.sv
`timescale 1ns/10ps
module dtp_range_chk
	import dtp_pkg::*;
(
	// Value and limits
	input  wire logic [15:0] value,
	input  wire logic [15:0] lo,
	input  wire logic [15:0] hi,
	// Verdict
	output logic             ok
);

	assign ok = (value >= lo) && (value <= hi);

endmodule // dtp_range_chk

// File: verilog/dtp_param_bank.sv
`timescale 1ns/10ps
`include "dtp_defines.svh"
// Function
// R1 - Restart method codes 0 to 3: alarm, restart at zero, resume on match, match then stop.
// R2 - Under-voltage beyond a ride-through of 3 to 250 tenths trips even in a restart mode.
// R3 - When under-voltage clears, wait the retry delay of 3 to 1000 tenths before running.
// R4 - The restart count selector holds 0 for at most 16 restarts or 1 for unlimited restarts.
// R5 - Each motor's thermal level holds 2000 to 12000 in 0.01 percent steps.
// R6 - Each motor's thermal curve takes codes 0, 1 and 2.
// R7 - The overload restriction mode takes codes 0, 1 and 2.
// R8 - The overload restriction level holds 2000 to 15000 in 0.01 percent steps.
// R9 - The overload deceleration rate holds 1 to 300 in 0.1 second steps.
// R10 - Each motor's overload source takes 0 for the level register or 1 for the analog input.
// R11 - Lock codes 0 and 1 block writes while the lock terminal is on; code 1 frees the setpoint.
// R12 - Lock codes 2 and 3 block writes always; code 3 also frees the frequency setpoint.
// R13 - The analog output gain holds 0 to 255 and scales the analog monitor output.
// R14 - The start frequency holds 5 to 99 in 0.1 Hz steps.
// R15 - A write outside a register's range or code set is refused and the old value stays.
// R16 - A locked write leaves the register unchanged; the lock mode register stays writable.
module dtp_param_bank
	import dtp_pkg::*;
#(
	parameter int STEP_CYCLES = `DTP_STEP_NS / `DTP_CLK_NS
)
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        clk_en,
	// Holding register port
	input  wire dtp_req_t    req,
	output dtp_rsp_t         rsp,
	// Terminals
	input  wire logic        lock_terminal,
	input  wire logic        undervoltage,
	input  wire logic        trip_clear,
	// Parameter values
	output logic [15:0]      restart_method,
	output logic [15:0]      thermal_level,
	output logic [15:0]      thermal_curve,
	output logic [15:0]      thermal_level_motor2,
	output logic [15:0]      thermal_curve_motor2,
	output logic [15:0]      overload_limit_mode,
	output logic [15:0]      overload_limit_level,
	output logic [15:0]      overload_decel_rate,
	output logic [15:0]      overload_limit_source,
	output logic [15:0]      overload_limit_source_motor2,
	output logic [15:0]      start_frequency,
	output logic [7:0]       analog_monitor_gain,
	// Lock view for the frequency setpoint
	output logic             setpoint_write_allowed,
	// Power failure handling
	output dtp_power_t       power
);

	localparam int IDX_METHOD   = 0;
	localparam int IDX_RIDE     = 1;
	localparam int IDX_WAIT     = 2;
	localparam int IDX_ALARM    = 3;
	localparam int IDX_COUNT    = 4;
	localparam int IDX_TLEVEL   = 5;
	localparam int IDX_TCURVE   = 6;
	localparam int IDX_OLMODE   = 7;
	localparam int IDX_OLLEVEL  = 8;
	localparam int IDX_OLDECEL  = 9;
	localparam int IDX_OLSRC    = 10;
	localparam int IDX_LOCK     = 11;
	localparam int IDX_AMGAIN   = 12;
	localparam int IDX_START    = 13;
	localparam int IDX_TLEVEL2  = 14;
	localparam int IDX_TCURVE2  = 15;
	localparam int IDX_OLSRC2   = 16;
	localparam int STEP_W       = $clog2(STEP_CYCLES + 1);

	localparam logic [63:0] REG_TAB [DTP_NREG] = '{
		`DTP_R_RESTART_METHOD,
		`DTP_R_UV_RIDE_TIME,
		`DTP_R_RESTART_WAIT,
		`DTP_R_PF_ALARM_EN,
		`DTP_R_RESTART_COUNT,
		`DTP_R_THERMAL_LEVEL,
		`DTP_R_THERMAL_CURVE,
		`DTP_R_OL_MODE,
		`DTP_R_OL_LEVEL,
		`DTP_R_OL_DECEL,
		`DTP_R_OL_SOURCE,
		`DTP_R_LOCK_MODE,
		`DTP_R_AM_GAIN,
		`DTP_R_START_FREQ,
		`DTP_R_THERMAL_LEVEL_M2,
		`DTP_R_THERMAL_CURVE_M2,
		`DTP_R_OL_SOURCE_M2
	};

	logic [15:0]         regs      [DTP_NREG];
	logic [DTP_NREG-1:0] hit;
	logic [DTP_NREG-1:0] in_range;
	logic [DTP_NREG-1:0] write_ok;
	logic [15:0]         hit_rdata;
	logic                status_hit;
	logic                any_hit;
	logic                locked;
	logic                lock_always;
	logic                lock_frees_freq;
	logic                wr_refused;
	logic [15:0]         status_word;
	logic [15:0]         next_rdata;
	logic                next_err;

	dtp_state_t          state;
	dtp_state_t          next_state;
	logic [STEP_W-1:0]   step_cnt;
	logic                step_tick;
	logic [15:0]         tenths;
	logic                ride_over;
	logic                wait_done;
	logic                count_exhausted;
	logic                go_restart;
	logic [4:0]          restarts;

	// Lock decode from current mode and terminal
	assign lock_always     = regs[IDX_LOCK] >= `DTP_LOCK_ALWAYS;
	assign lock_frees_freq = regs[IDX_LOCK][`DTP_LOCK_FREQ_BIT];
	// R11 terminal gated lock
	// R12 unconditional lock
	assign locked          = lock_always || lock_terminal;
	// R11 setpoint exemption
	// R12 setpoint exemption
	assign setpoint_write_allowed = !locked || lock_frees_freq;

	// Per-register decode, range check and store
	genvar gi;
	generate
		for (gi = 0; gi < DTP_NREG; gi++) begin : g_reg
			assign hit[gi] = req.addr == REG_TAB[gi][`DTP_TAB_OFS_HI:`DTP_TAB_OFS_LO];

			// R1 R4 R5 R6 R7 R8 R9 R10 R13 R14 range limits
			dtp_range_chk u_chk (
				.value (req.wdata),
				.lo    (REG_TAB[gi][`DTP_TAB_MIN_HI:`DTP_TAB_MIN_LO]),
				.hi    (REG_TAB[gi][`DTP_TAB_MAX_HI:`DTP_TAB_MAX_LO]),
				.ok    (in_range[gi])
			);

			// R15 R16 refuse bad or locked
			assign write_ok[gi] = req.wr && hit[gi] && in_range[gi] &&
				(!locked || gi == IDX_LOCK);

			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					regs[gi] <= REG_TAB[gi][`DTP_TAB_RST_HI:`DTP_TAB_RST_LO];
				end else if (clk_en && write_ok[gi]) begin
					regs[gi] <= req.wdata;
				end
			end
		end
	endgenerate

	always_comb begin
		hit_rdata = 16'h0000;
		for (int i = 0; i < DTP_NREG; i++) begin
			if (hit[i]) begin
				hit_rdata = regs[i];
			end
		end
	end

	assign status_hit  = req.addr == `DTP_STATUS_OFS;
	assign any_hit     = |hit;
	assign status_word = {9'h000, restarts, state};
	// R15 refused write reported
	assign wr_refused  = !any_hit || !(|write_ok);
	assign next_rdata  = status_hit ? status_word : (any_hit ? hit_rdata : 16'h0000);
	// Status is read-only, so a write to it is an error
	assign next_err    = req.wr ? wr_refused : !(any_hit || status_hit);

	// Answer one cycle after the request
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rsp <= '0;
		end else if (clk_en) begin
			rsp.ack   <= req.wr || req.rd;
			rsp.err   <= (req.wr || req.rd) && next_err;
			rsp.rdata <= req.rd ? next_rdata : 16'h0000;
		end
	end

	// Tenth-second time base, restarted on every state change
	assign step_tick = step_cnt == STEP_W'(STEP_CYCLES - 1);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			step_cnt <= '0;
			tenths   <= 16'h0000;
		end else if (clk_en) begin
			if (next_state != state) begin
				step_cnt <= '0;
				tenths   <= 16'h0000;
			end else if (step_tick) begin
				step_cnt <= '0;
				tenths   <= tenths + 16'h0001;
			end else begin
				step_cnt <= step_cnt + STEP_W'(1);
			end
		end
	end

	// R2 ride-through exceeded
	assign ride_over       = tenths >= regs[IDX_RIDE] && step_tick;
	// R3 retry delay elapsed
	assign wait_done       = tenths + 16'h0001 >= regs[IDX_WAIT] && step_tick;
	// R4 restart count policy
	assign count_exhausted = regs[IDX_COUNT] == 16'h0000 && restarts >= `DTP_RESTART_LIMIT;
	assign go_restart      = state == ST_WAIT && wait_done && !undervoltage;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_RUN: begin
				if (undervoltage) begin
					next_state = ST_RIDE;
				end
			end
			ST_RIDE: begin
				// R2 trip despite restart mode
				if (undervoltage && ride_over) begin
					next_state = ST_TRIP;
				// R1 alarm-only method
				end else if (!undervoltage && regs[IDX_METHOD] == `DTP_METHOD_ALARM) begin
					next_state = ST_TRIP;
				end else if (!undervoltage && count_exhausted) begin
					next_state = ST_TRIP;
				end else if (!undervoltage) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// R3 wait before running
				if (undervoltage) begin
					next_state = ST_RIDE;
				end else if (wait_done) begin
					next_state = ST_RUN;
				end
			end
			ST_TRIP: begin
				if (trip_clear && !undervoltage) begin
					next_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_RUN;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// Restart counter, cleared by a trip reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			restarts <= 5'd0;
		end else if (clk_en) begin
			if (state == ST_TRIP && next_state == ST_RUN) begin
				restarts <= 5'd0;
			end else if (go_restart && restarts != 5'h1F) begin
				restarts <= restarts + 5'd1;
			end
		end
	end

	// R1 restart kind per method
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			power <= '0;
		end else if (clk_en) begin
			power.motor_enable     <= next_state == ST_RUN;
			power.trip             <= next_state == ST_TRIP;
			power.trip_alarm       <= next_state == ST_TRIP && regs[IDX_ALARM][0];
			power.restart_pulse    <= go_restart;
			power.freq_match       <= go_restart && regs[IDX_METHOD] >= 16'h0002;
			power.stop_after_match <= go_restart && regs[IDX_METHOD] == 16'h0003;
			power.restarts         <= restarts;
		end
	end

	// Parameter values towards the drive
	assign restart_method               = regs[IDX_METHOD];
	assign thermal_level                = regs[IDX_TLEVEL];
	assign thermal_curve                = regs[IDX_TCURVE];
	assign thermal_level_motor2         = regs[IDX_TLEVEL2];
	assign thermal_curve_motor2         = regs[IDX_TCURVE2];
	assign overload_limit_mode          = regs[IDX_OLMODE];
	assign overload_limit_level         = regs[IDX_OLLEVEL];
	assign overload_decel_rate          = regs[IDX_OLDECEL];
	assign overload_limit_source        = regs[IDX_OLSRC];
	assign overload_limit_source_motor2 = regs[IDX_OLSRC2];
	assign start_frequency              = regs[IDX_START];
	// R13 gain fits eight bits
	assign analog_monitor_gain          = regs[IDX_AMGAIN][7:0];

endmodule // dtp_param_bank

// File: dv/dtp_param_bank_chk.sv
`timescale 1ns/10ps
module dtp_param_bank_chk
	import dtp_pkg::*;
#(
	parameter int STEP_CYCLES = 2
)
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic        clk_en,
	// Register port
	input wire dtp_req_t    req,
	input wire dtp_rsp_t    rsp,
	// Terminals
	input wire logic        lock_terminal,
	input wire logic        undervoltage,
	input wire logic        trip_clear,
	// Watched values
	input wire logic [15:0] restart_method,
	input wire logic [15:0] overload_limit_mode,
	input wire logic [15:0] start_frequency,
	input wire dtp_power_t  power
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire wr_en  = clk_en && req.wr;
	wire any_en = clk_en && (req.wr || req.rd);
	wire sf_bad = (req.wdata < 16'h0005) || (req.wdata > 16'h0063);

	ack_follow_a: assert property (any_en |=> rsp.ack)
		else $error("no answer one cycle after a request");
	ack_quiet_a: assert property (clk_en && !req.wr && !req.rd |=> !rsp.ack)
		else $error("answer without a request");
	method_refuse_a: assert property (wr_en && req.addr == 16'h10A5 && req.wdata > 16'h0003
		|=> rsp.err && $stable(restart_method)) else $error("bad restart code taken");
	method_take_a: assert property (wr_en && req.addr == 16'h10A5 ##1 rsp.ack && !rsp.err
		|-> restart_method == $past(req.wdata)) else $error("restart code not stored");
	start_refuse_a: assert property (wr_en && req.addr == 16'h10D1 && sf_bad
		|=> rsp.err && $stable(start_frequency)) else $error("bad start frequency taken");
	term_lock_a: assert property (wr_en && lock_terminal && req.addr == 16'h10B5
		|=> rsp.err && $stable(overload_limit_mode)) else $error("write passed the lock");
	ride_enter_a: assert property (power.motor_enable && undervoltage && clk_en
		|=> !power.motor_enable) else $error("motor kept running on undervoltage");
	trip_hold_a: assert property (power.trip && clk_en && (undervoltage || !trip_clear)
		|=> power.trip) else $error("trip released early");
	restart_run_a: assert property (power.restart_pulse |-> power.motor_enable && !power.trip)
		else $error("restart pulse without running");

	cover property (wr_en ##1 rsp.ack && !rsp.err);
	cover property (wr_en ##1 rsp.err);
	cover property ($rose(power.trip));
	cover property (power.restart_pulse);
endmodule // dtp_param_bank_chk

bind dtp_param_bank dtp_param_bank_chk #(.STEP_CYCLES(STEP_CYCLES)) u_chk (.sys_clk, .nrst,
	.clk_en, .req, .rsp, .lock_terminal, .undervoltage, .trip_clear, .restart_method,
	.overload_limit_mode, .start_frequency, .power);

// File: dv/dtp_master.sv
`timescale 1ns/10ps
module dtp_master
	import dtp_pkg::*;
(
	// Clock
	input wire logic     sys_clk,
	// Holding register port
	output dtp_req_t     req,
	input wire dtp_rsp_t rsp
);
	initial req = '{1'b0, 1'b0, 16'h0000, 16'h0000};

	// One cycle of request only, a longer hold would repeat the write
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic k, output logic e, output logic [15:0] q);
		@(negedge sys_clk);
		req <= '{w, ~w, a, d};
		@(negedge sys_clk);
		// Idle bus shows inverted values, never a stale copy
		req <= '{1'b0, 1'b0, ~a, ~d};
		k = rsp.ack;
		e = rsp.err;
		q = rsp.rdata;
	endtask
endmodule // dtp_master

// File: dv/testbench.sv
`timescale 1ns/10ps
module testbench
	import dtp_pkg::*;
;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] r;
		logic [15:0] g;
		logic [15:0] b;
	} dtp_case_t;
	logic       sys_clk = 1'b0;
	logic       nrst = 1'b0;
	logic       lock_terminal = 1'b0;
	logic       undervoltage = 1'b0;
	logic       trip_clear = 1'b0;
	logic [7:0] gain;
	logic       setpoint_write_allowed;
	dtp_req_t   req;
	dtp_rsp_t   rsp;
	dtp_power_t power;
	logic [15:0] par [11];
	int         src [11] = '{0, 5, 6, 13, 14, 7, 8, 9, 10, 15, 12};
	int         bad_count = 0;
	int         total_checks = 0;
	dtp_case_t  tab [16] = '{
		'{16'h10A5, 16'h0000, 16'h0003, 16'h0004}, '{16'h10A6, 16'h000A, 16'h00FA, 16'h0002},
		'{16'h10A7, 16'h000A, 16'h03E8, 16'h03E9}, '{16'h10A8, 16'h0000, 16'h0001, 16'h0002},
		'{16'h10A9, 16'h0000, 16'h0001, 16'h0002}, '{16'h10AD, 16'h2710, 16'h2EE0, 16'h07CF},
		'{16'h10AE, 16'h0001, 16'h0002, 16'h0003}, '{16'h10B5, 16'h0001, 16'h0002, 16'h0003},
		'{16'h10B6, 16'h3A98, 16'h07D0, 16'h3A99}, '{16'h10B7, 16'h000A, 16'h012C, 16'h0000},
		'{16'h10BB, 16'h0000, 16'h0001, 16'h0002}, '{16'h10CF, 16'h0064, 16'h00FF, 16'h0100},
		'{16'h10D1, 16'h0005, 16'h0063, 16'h0004}, '{16'h1526, 16'h2710, 16'h07D0, 16'h2EE1},
		'{16'h1527, 16'h0001, 16'h0000, 16'h0003}, '{16'h152B, 16'h0000, 16'h0001, 16'h0002}};

	always #2 sys_clk = ~sys_clk;

	dtp_master u_dtp_master (.sys_clk(sys_clk), .req(req), .rsp(rsp));

	// Short tenth-second tick keeps the ride and wait counts brief
	dtp_param_bank #(.STEP_CYCLES(2)) u_dtp_param_bank (.sys_clk(sys_clk), .nrst(nrst),
		.clk_en(1'b1), .req(req), .rsp(rsp), .lock_terminal(lock_terminal),
		.undervoltage(undervoltage), .trip_clear(trip_clear), .restart_method(par[0]),
		.thermal_level(par[1]), .thermal_curve(par[2]), .thermal_level_motor2(par[3]),
		.thermal_curve_motor2(par[4]), .overload_limit_mode(par[5]),
		.overload_limit_level(par[6]), .overload_decel_rate(par[7]),
		.overload_limit_source(par[8]), .overload_limit_source_motor2(par[9]),
		.start_frequency(par[10]),
		.analog_monitor_gain(gain), .setpoint_write_allowed(setpoint_write_allowed),
		.power(power));

	task automatic chk_word(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			bad_count++;
			$display("BAD %0t word %h expected %h", $time, g, x);
		end
	endtask

	task automatic chk_bit(input logic g, input logic x);
		total_checks++;
		if (g !== x) begin
			bad_count++;
			$display("BAD %0t flag %b expected %b", $time, g, x);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
		logic        k;
		logic        er;
		logic [15:0] q;
		u_dtp_master.xfer(1'b1, a, d, k, er, q);
		chk_bit(k, 1'b1);
		chk_bit(er, e);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] x, input logic e);
		logic        k;
		logic        er;
		logic [15:0] q;
		u_dtp_master.xfer(1'b0, a, 16'h0000, k, er, q);
		chk_bit(k, 1'b1);
		chk_bit(er, e);
		chk_word(q, x);
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#20000;
		bad_count++;
		$display("BAD %0t run hung", $time);
		complete_run;
	end

	initial begin
		cycles(4);
		nrst = 1'b1;
		foreach (tab[i]) rd(tab[i].a, tab[i].r, 1'b0);
		foreach (tab[i]) begin
			wr(tab[i].a, tab[i].g, 1'b0);
			wr(tab[i].a, tab[i].b, 1'b1);
			rd(tab[i].a, tab[i].g, 1'b0);
		end
		foreach (src[k]) chk_word(par[k], tab[src[k]].g);
		wr(16'h1600, 16'h0000, 1'b1);
		rd(16'h10A4, 16'h0000, 1'b1);
		wr(16'h10BC, 16'h0002, 1'b0);
		wr(16'h10CF, 16'h0005, 1'b1);
		rd(16'h10CF, 16'h00FF, 1'b0);
		chk_bit(setpoint_write_allowed, 1'b0);
		wr(16'h10BC, 16'h0003, 1'b0);
		chk_bit(setpoint_write_allowed, 1'b1);
		wr(16'h10BC, 16'h0000, 1'b0);
		lock_terminal = 1'b1;
		wr(16'h10B5, 16'h0000, 1'b1);
		chk_bit(setpoint_write_allowed, 1'b0);
		wr(16'h10BC, 16'h0001, 1'b0);
		chk_bit(setpoint_write_allowed, 1'b1);
		lock_terminal = 1'b0;
		wr(16'h10CF, 16'h0007, 1'b0);
		chk_word({8'h00, gain}, 16'h0007);
		wr(16'h10A6, 16'h000A, 1'b0);
		wr(16'h10A7, 16'h0003, 1'b0);
		wr(16'h10A5, 16'h0001, 1'b0);
		undervoltage = 1'b1;
		cycles(5);
		undervoltage = 1'b0;
		for (int n = 0; n < 30 && power.restart_pulse !== 1'b1; n++) cycles(1);
		chk_bit(power.restart_pulse, 1'b1);
		chk_bit(power.motor_enable, 1'b1);
		chk_bit(power.freq_match, 1'b0);
		cycles(1);
		chk_word({11'h000, power.restarts}, 16'h0001);
		rd(16'h1600, 16'h0004, 1'b0);
		wr(16'h10A5, 16'h0003, 1'b0);
		undervoltage = 1'b1;
		cycles(5);
		undervoltage = 1'b0;
		for (int n = 0; n < 30 && power.restart_pulse !== 1'b1; n++) cycles(1);
		chk_bit(power.freq_match, 1'b1);
		chk_bit(power.stop_after_match, 1'b1);
		undervoltage = 1'b1;
		cycles(40);
		chk_bit(power.trip, 1'b1);
		chk_bit(power.trip_alarm, 1'b1);
		trip_clear = 1'b1;
		cycles(3);
		chk_bit(power.trip, 1'b1);
		undervoltage = 1'b0;
		cycles(3);
		chk_bit(power.trip, 1'b0);
		trip_clear = 1'b0;
		wr(16'h10A5, 16'h0000, 1'b0);
		undervoltage = 1'b1;
		cycles(5);
		undervoltage = 1'b0;
		cycles(12);
		chk_bit(power.trip, 1'b1);
		trip_clear = 1'b1;
		cycles(3);
		trip_clear = 1'b0;
		wr(16'h10A9, 16'h0000, 1'b0);
		wr(16'h10A5, 16'h0001, 1'b0);
		// Sixteen restarts allowed, the next one trips
		repeat (16) begin
			undervoltage = 1'b1;
			cycles(2);
			undervoltage = 1'b0;
			cycles(12);
		end
		chk_word({11'h000, power.restarts}, 16'h0010);
		chk_bit(power.motor_enable, 1'b1);
		undervoltage = 1'b1;
		cycles(2);
		undervoltage = 1'b0;
		cycles(4);
		chk_bit(power.trip, 1'b1);
		complete_run;
	end
endmodule // testbench
